// ===== rtl/board_audio_route_config.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "board_audio_route_map.svh"
module board_audio_route_config (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Board straps
  input wire logic [`SW_W-1:0] switch_bank_in,
  input wire logic pc_cable_present_in,
  input wire logic control_direction_jumper_in,
  // Codec clocks and data
  input wire logic codec_mclk_in,
  output logic codec_mclk_out,
  output logic codec_mclk_oe_out,
  input wire logic codec_sclk_in,
  output logic codec_sclk_out,
  output logic codec_sclk_oe_out,
  input wire logic codec_lrck_in,
  output logic codec_lrck_out,
  output logic codec_lrck_oe_out,
  input wire logic codec_serial_data_out_in,
  output logic codec_serial_data_in_out,
  // Receiver clocks and data
  input wire logic rx_mclk_in,
  input wire logic rx_sclk_in,
  output logic rx_sclk_out,
  output logic rx_sclk_oe_out,
  input wire logic rx_lrck_in,
  output logic rx_lrck_out,
  output logic rx_lrck_oe_out,
  input wire logic rx_serial_data_out_in,
  // Transmitter clocks and data
  output logic tx_mclk_out,
  input wire logic tx_sclk_in,
  output logic tx_sclk_out,
  output logic tx_sclk_oe_out,
  input wire logic tx_lrck_in,
  output logic tx_lrck_out,
  output logic tx_lrck_oe_out,
  output logic tx_serial_data_in_out,
  // PCM header
  input wire logic pcm_header_mclk_in,
  output logic pcm_header_mclk_out,
  output logic pcm_header_mclk_oe_out,
  input wire logic pcm_header_sclk_in,
  output logic pcm_header_sclk_out,
  output logic pcm_header_sclk_oe_out,
  input wire logic pcm_header_lrck_in,
  output logic pcm_header_lrck_out,
  output logic pcm_header_lrck_oe_out,
  output logic pcm_header_serial_data_out,
  input wire logic pcm_header_serial_data_in,
  // Two-pin data headers
  input wire logic tx_data_header_in,
  output logic rx_data_header_out,
  // Control port paths
  input wire logic [2:0] pc_ctrl_in,
  output logic [2:0] codec_ctrl_out,
  input wire logic [2:0] control_header_in,
  output logic [2:0] control_header_out,
  output logic control_header_oe_out,
  // Device configuration
  output logic format_select_out,
  output logic mclk_ratio_128_out,
  output board_audio_route_pkg::speed_mode_t speed_mode_out,
  output logic spdif_coax_select_out
);
  import board_audio_route_pkg::*;

  logic [`SW_W-1:0] sw_level;
  logic [`SW_W-1:0] sw_cfg;
  logic sw_captured;
  logic cable_level;
  logic jumper_level;
  logic [`CFG_W-1:0] pc_cfg_r;
  logic [`CFG_W-1:0] act_cfg_r;
  logic [`CFG_W-1:0] act_cfg_nxt;
  master_sel_t master_sel;
  mclk_src_t mclk_src;
  logic board_mclk;
  logic board_sclk;
  logic board_lrck;
  logic aw_held_r;
  logic [3:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // Picks the line driven by whichever party is clock master.
  function automatic logic pick_master(input master_sel_t sel, input logic c,
                                       input logic r, input logic t, input logic h);
    case (sel)
      MST_CODEC: pick_master = c;
      MST_RX: pick_master = r;
      MST_TX: pick_master = t;
      default: pick_master = h;
    endcase
  endfunction : pick_master

  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == `ADDR_PC_CFG) || (addr == `ADDR_STATUS) ||
                (addr == `ADDR_SWITCH);
  endfunction : is_mapped

  pin_sync #(.W(`SW_W), .INIT(`SW_RESET)) u_sw_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(switch_bank_in),
    .level_out(sw_level)
  );

  pin_sync #(.W(2), .INIT(2'h0)) u_strap_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in({control_direction_jumper_in, pc_cable_present_in}),
    .level_out({jumper_level, cable_level})
  );

  config_capture u_capture (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .sw_level_in(sw_level),
    .sw_cfg_out(sw_cfg),
    .captured_out(sw_captured)
  );

  // The PC path owns the settings while its cable is in; the header-data
  // choice for the transmitter exists only on that path.
  always_comb begin
    if (cable_level) begin
      act_cfg_nxt = pc_cfg_r;
    end else begin
      act_cfg_nxt = {1'b0, sw_cfg};
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      act_cfg_r <= `CFG_RESET;
    end else begin
      act_cfg_r <= act_cfg_nxt;
    end
  end

  assign master_sel = master_sel_t'(act_cfg_r[`CFG_MS_LSB +: 2]);
  assign mclk_src = mclk_src_t'(act_cfg_r[`CFG_MCLK_LSB +: 2]);

  // Clock routing is pure gating: re-timing audio clocks in clk_sys would
  // add jitter and cannot keep up with a 256 Fs master clock.
  always_comb begin
    case (mclk_src)
      MCLK_FROM_RX: board_mclk = rx_mclk_in;
      MCLK_FROM_CODEC: board_mclk = codec_mclk_in;
      default: board_mclk = pcm_header_mclk_in;
    endcase
  end

  assign codec_mclk_out = board_mclk;
  assign codec_mclk_oe_out = (mclk_src != MCLK_FROM_CODEC);
  assign tx_mclk_out = board_mclk;
  assign pcm_header_mclk_out = board_mclk;
  assign pcm_header_mclk_oe_out = (mclk_src == MCLK_FROM_RX) ||
                                  (mclk_src == MCLK_FROM_CODEC);

  assign board_sclk = pick_master(master_sel, codec_sclk_in, rx_sclk_in, tx_sclk_in,
                                  pcm_header_sclk_in);
  assign board_lrck = pick_master(master_sel, codec_lrck_in, rx_lrck_in, tx_lrck_in,
                                  pcm_header_lrck_in);

  assign codec_sclk_out = board_sclk;
  assign codec_lrck_out = board_lrck;
  assign codec_sclk_oe_out = (master_sel != MST_CODEC);
  assign codec_lrck_oe_out = (master_sel != MST_CODEC);
  assign rx_sclk_out = board_sclk;
  assign rx_lrck_out = board_lrck;
  assign rx_sclk_oe_out = (master_sel != MST_RX);
  assign rx_lrck_oe_out = (master_sel != MST_RX);
  assign tx_sclk_out = board_sclk;
  assign tx_lrck_out = board_lrck;
  assign tx_sclk_oe_out = (master_sel != MST_TX);
  assign tx_lrck_oe_out = (master_sel != MST_TX);
  assign pcm_header_sclk_out = board_sclk;
  assign pcm_header_lrck_out = board_lrck;
  assign pcm_header_sclk_oe_out = (master_sel != MST_HDR);
  assign pcm_header_lrck_oe_out = (master_sel != MST_HDR);

  // Serial data paths.
  assign codec_serial_data_in_out = act_cfg_r[`CFG_SERIAL_DATA_IN_HDR_BIT] ?
                                    pcm_header_serial_data_in :
                                    rx_serial_data_out_in;
  assign pcm_header_serial_data_out = codec_serial_data_out_in;
  assign rx_data_header_out = rx_serial_data_out_in;
  assign tx_serial_data_in_out = act_cfg_r[`CFG_TX_HDR_BIT] ? tx_data_header_in :
                                 codec_serial_data_out_in;

  // Control port: the header mirrors the PC lines unless the jumper turns it round.
  assign codec_ctrl_out = jumper_level ? control_header_in : pc_ctrl_in;
  assign control_header_out = pc_ctrl_in;
  assign control_header_oe_out = !jumper_level;

  assign format_select_out = act_cfg_r[`CFG_I2S_BIT];
  assign mclk_ratio_128_out = act_cfg_r[`CFG_R128_BIT];
  assign speed_mode_out = speed_mode_t'(act_cfg_r[`CFG_SPEED_LSB +: 2]);
  assign spdif_coax_select_out = act_cfg_r[`CFG_COAX_BIT];

  // AXI4-Lite write side: address and data are caught in either order.
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (aw_held_r && w_held_r) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (aw_held_r && w_held_r) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (aw_held_r && w_held_r) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the PC configuration word is writable; byte lanes apply.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pc_cfg_r <= `CFG_RESET;
    end else if (aw_held_r && w_held_r && aw_addr_r == `ADDR_PC_CFG) begin
      if (w_strb_r[0]) begin
        pc_cfg_r[7:0] <= w_data_r[7:0];
      end
      if (w_strb_r[1]) begin
        pc_cfg_r[`CFG_W-1:8] <= w_data_r[`CFG_W-1:8];
      end
    end
  end

  // AXI4-Lite read side: one cycle from address to data.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `ADDR_PC_CFG: s_axi_rdata <= {21'h0, pc_cfg_r};
        `ADDR_STATUS: s_axi_rdata <= {13'h0, sw_captured, jumper_level, cable_level,
                                      5'h0, act_cfg_r};
        `ADDR_SWITCH: s_axi_rdata <= {22'h0, sw_cfg};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence pc_write_cfg_s;
    aw_held_r && w_held_r && aw_addr_r == `ADDR_PC_CFG && (&w_strb_r[1:0]);
  endsequence

  AST_MASTER_OE: assert property (
    (master_sel == MST_RX) |-> (!rx_sclk_oe_out && codec_sclk_oe_out &&
                                tx_sclk_oe_out && pcm_header_sclk_oe_out &&
                                codec_sclk_out == rx_sclk_in))
    else $error("Bit clock master routing wrong.");
  AST_MCLK_SRC: assert property (
    (mclk_src == MCLK_FROM_HDR_ALT) |-> (codec_mclk_out == pcm_header_mclk_in &&
                                         !pcm_header_mclk_oe_out))
    else $error("Master clock not taken from header.");
  AST_SERIAL_DATA_IN_SEL: assert property (
    !act_cfg_r[`CFG_SERIAL_DATA_IN_HDR_BIT] |-> codec_serial_data_in_out == rx_serial_data_out_in)
    else $error("Codec input data not from receiver.");
  AST_PC_APPLY: assert property (
    pc_write_cfg_s ##1 (cable_level && !aw_held_r)
    |=> act_cfg_r == $past(pc_cfg_r))
    else $error("PC configuration not applied.");
  AST_RESET_DEFAULT: assert property (
    (!sw_captured && !cable_level) |-> (speed_mode_out == SPEED_SINGLE &&
                                        master_sel == MST_CODEC && !format_select_out))
    else $error("Default settings wrong before capture.");
  AST_SW_HELD: assert property (
    sw_captured |=> (sw_captured && $stable(sw_cfg)))
    else $error("Captured switch settings changed.");
  AST_SW_GATED: assert property (
    cable_level [*2] |-> act_cfg_r == $past(pc_cfg_r))
    else $error("Switch bank not disabled under PC control.");
  AST_TX_SRC: assert property (
    !cable_level [*2] |-> tx_serial_data_in_out == codec_serial_data_out_in)
    else $error("Transmitter data not from codec.");
  AST_CTRL_DIR: assert property (
    jumper_level |-> (!control_header_oe_out && codec_ctrl_out == control_header_in))
    else $error("Control header direction wrong.");
  AST_SPEED_MAP: assert property (
    !cable_level [*2] |-> speed_mode_out == $past(sw_cfg[`CFG_SPEED_LSB +: 2]))
    else $error("Speed mode not from switch bank.");
endmodule : board_audio_route_config

// ===== rtl/board_audio_route_map.svh
`ifndef BOARD_AUDIO_ROUTE_MAP_SVH
`define BOARD_AUDIO_ROUTE_MAP_SVH

// Configuration word layout, shared by the switch bank and the PC register.
`define CFG_W 11
`define SW_W 10
`define CFG_MS_LSB 0
`define CFG_MCLK_LSB 2
`define CFG_SERIAL_DATA_IN_HDR_BIT 4
`define CFG_COAX_BIT 5
`define CFG_I2S_BIT 6
`define CFG_R128_BIT 7
`define CFG_SPEED_LSB 8
`define CFG_TX_HDR_BIT 10

// Every selection defaults to zero except the speed mode, which is 01.
`define CFG_RESET 11'h100
`define SW_RESET 10'h100

// Register byte addresses.
`define ADDR_PC_CFG 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_SWITCH 4'h8

// Status word layout.
`define ST_CABLE_BIT 16
`define ST_JUMPER_BIT 17
`define ST_CAPTURED_BIT 18

// AXI4-Lite responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Cycles that the switch synchroniser needs before its output is trusted.
`define SETTLE_CYC 3'h4

`endif

// ===== rtl/board_audio_route_pkg.sv
package board_audio_route_pkg;

  typedef enum logic [1:0] {
    MST_CODEC = 2'b00,
    MST_RX = 2'b01,
    MST_TX = 2'b10,
    MST_HDR = 2'b11
  } master_sel_t;

  typedef enum logic [1:0] {
    MCLK_FROM_RX = 2'b00,
    MCLK_FROM_CODEC = 2'b01,
    MCLK_FROM_HDR = 2'b10,
    MCLK_FROM_HDR_ALT = 2'b11
  } mclk_src_t;

  typedef enum logic [1:0] {
    SPEED_SINGLE_DEEMPH = 2'b00,
    SPEED_SINGLE = 2'b01,
    SPEED_DOUBLE = 2'b10,
    SPEED_QUAD = 2'b11
  } speed_mode_t;

endpackage : board_audio_route_pkg

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; the output moves only when stages two and three agree.
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      meta_r <= pin_in;
      s2_r <= meta_r;
      s3_r <= s2_r;
    end
  end

  // Each bit filters on its own so that one bouncing switch holds back no other.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= INIT;
    end else begin
      level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
    end
  end
endmodule : pin_sync

// ===== rtl/config_capture.sv
`timescale 1ns/10ps
`include "board_audio_route_map.svh"
// Takes one snapshot of the switch bank after reset release and holds it.
module config_capture (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Synchronised switch levels
  input wire logic [`SW_W-1:0] sw_level_in,
  // Held settings
  output logic [`SW_W-1:0] sw_cfg_out,
  output logic captured_out
);
  logic [2:0] settle_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      settle_r <= 3'h0;
    end else if (settle_r != `SETTLE_CYC) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // Later switch moves are ignored until the next board reset.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sw_cfg_out <= `SW_RESET;
      captured_out <= 1'b0;
    end else if (!captured_out && settle_r == `SETTLE_CYC) begin
      sw_cfg_out <= sw_level_in;
      captured_out <= 1'b1;
    end
  end
endmodule : config_capture

// ===== dv/audio_far_side.sv
`timescale 1ns/10ps
// Codec, receiver, transmitter and header. Bit and word clock vectors are ordered codec, rx, tx, header.
module audio_far_side (
  // Clock
  input wire logic clk_sys_in,
  // Board side of the shared clock lines
  input wire logic [3:0] sclk_oe_in,
  input wire logic [3:0] sclk_brd_in,
  input wire logic [3:0] lrck_oe_in,
  input wire logic [3:0] lrck_brd_in,
  input wire logic [1:0] mclk_oe_in,
  input wire logic [1:0] mclk_brd_in,
  // Resolved lines: mclk is codec, rx, header; data is codec out, rx out, header in, tx header
  output logic [3:0] sclk_out,
  output logic [3:0] lrck_out,
  output logic [2:0] mclk_out,
  output logic [3:0] data_out
);
  logic [3:0] cnt_r = 4'h0;
  always_ff @(posedge clk_sys_in) begin
    cnt_r <= cnt_r + 4'h1;
  end
  // A party lets go of any line that the board drives, so the wire shows the board level.
  assign sclk_out = (sclk_oe_in & sclk_brd_in) | (~sclk_oe_in & cnt_r);
  assign lrck_out = (lrck_oe_in & lrck_brd_in) | (~lrck_oe_in & ({cnt_r[2:0], cnt_r[3]} ^ 4'h6));
  assign mclk_out[0] = mclk_oe_in[0] ? mclk_brd_in[0] : ~cnt_r[1];
  assign mclk_out[1] = cnt_r[0] ^ cnt_r[1];
  assign mclk_out[2] = mclk_oe_in[1] ? mclk_brd_in[1] : ~cnt_r[2];
  assign data_out = {cnt_r[2] ^ cnt_r[3], cnt_r[1] ^ cnt_r[2], cnt_r[0] ^ cnt_r[3], cnt_r[0] ^ cnt_r[2]};
endmodule : audio_far_side

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
  import board_audio_route_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] switch_bank_in = 10'h100;
  logic pc_cable_present_in = 1'b0, control_direction_jumper_in = 1'b0;
  logic [2:0] pc_ctrl_in = 3'h5, control_header_in = 3'h2, codec_ctrl_out, control_header_out;
  logic codec_mclk_out, codec_mclk_oe_out, pcm_header_mclk_out, pcm_header_mclk_oe_out;
  logic codec_sclk_out, codec_sclk_oe_out, rx_sclk_out, rx_sclk_oe_out, tx_mclk_out;
  logic tx_sclk_out, tx_sclk_oe_out, pcm_header_sclk_out, pcm_header_sclk_oe_out;
  logic codec_lrck_out, codec_lrck_oe_out, rx_lrck_out, rx_lrck_oe_out;
  logic tx_lrck_out, tx_lrck_oe_out, pcm_header_lrck_out, pcm_header_lrck_oe_out;
  logic codec_serial_data_in_out, tx_serial_data_in_out, pcm_header_serial_data_out;
  logic rx_data_header_out, control_header_oe_out, format_select_out, mclk_ratio_128_out;
  logic spdif_coax_select_out;
  speed_mode_t speed_mode_out;
  wire logic [3:0] s_i, l_i, dat;
  wire logic [2:0] m_i;
  wire logic [3:0] s_oe = {pcm_header_sclk_oe_out, tx_sclk_oe_out, rx_sclk_oe_out, codec_sclk_oe_out};
  wire logic [3:0] s_o = {pcm_header_sclk_out, tx_sclk_out, rx_sclk_out, codec_sclk_out};
  wire logic [3:0] l_oe = {pcm_header_lrck_oe_out, tx_lrck_oe_out, rx_lrck_oe_out, codec_lrck_oe_out};
  wire logic [3:0] l_o = {pcm_header_lrck_out, tx_lrck_out, rx_lrck_out, codec_lrck_out};
  wire logic codec_sclk_in = s_i[0], rx_sclk_in = s_i[1], tx_sclk_in = s_i[2];
  wire logic pcm_header_sclk_in = s_i[3], codec_lrck_in = l_i[0], rx_lrck_in = l_i[1];
  wire logic tx_lrck_in = l_i[2], pcm_header_lrck_in = l_i[3], codec_mclk_in = m_i[0];
  wire logic rx_mclk_in = m_i[1], pcm_header_mclk_in = m_i[2], codec_serial_data_out_in = dat[0];
  wire logic rx_serial_data_out_in = dat[1], pcm_header_serial_data_in = dat[2];
  wire logic tx_data_header_in = dat[3];
  wire logic [2:0] cfg3 = {format_select_out, mclk_ratio_128_out, spdif_coax_select_out};
  int error_cnt = 0, total_checks = 0, cyc = 0;

  board_audio_route_config u_dut (.clk_sys_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .switch_bank_in, .pc_cable_present_in,
    .control_direction_jumper_in, .codec_mclk_in, .codec_mclk_out, .codec_mclk_oe_out,
    .codec_sclk_in, .codec_sclk_out, .codec_sclk_oe_out, .codec_lrck_in, .codec_lrck_out,
    .codec_lrck_oe_out, .codec_serial_data_out_in, .codec_serial_data_in_out, .rx_mclk_in,
    .rx_sclk_in, .rx_sclk_out, .rx_sclk_oe_out, .rx_lrck_in, .rx_lrck_out, .rx_lrck_oe_out,
    .rx_serial_data_out_in, .tx_mclk_out, .tx_sclk_in, .tx_sclk_out, .tx_sclk_oe_out,
    .tx_lrck_in, .tx_lrck_out, .tx_lrck_oe_out, .tx_serial_data_in_out, .pcm_header_mclk_in,
    .pcm_header_mclk_out, .pcm_header_mclk_oe_out, .pcm_header_sclk_in, .pcm_header_sclk_out,
    .pcm_header_sclk_oe_out, .pcm_header_lrck_in, .pcm_header_lrck_out, .pcm_header_lrck_oe_out,
    .pcm_header_serial_data_out, .pcm_header_serial_data_in, .tx_data_header_in,
    .rx_data_header_out, .pc_ctrl_in, .codec_ctrl_out, .control_header_in, .control_header_out,
    .control_header_oe_out, .format_select_out, .mclk_ratio_128_out, .speed_mode_out,
    .spdif_coax_select_out);

  audio_far_side u_far (.clk_sys_in, .sclk_oe_in(s_oe), .sclk_brd_in(s_o), .lrck_oe_in(l_oe),
    .lrck_brd_in(l_o), .mclk_oe_in({pcm_header_mclk_oe_out, codec_mclk_oe_out}),
    .mclk_brd_in({pcm_header_mclk_out, codec_mclk_out}), .sclk_out(s_i), .lrck_out(l_i),
    .mclk_out(m_i), .data_out(dat));

  always #12.5 clk_sys_in = ~clk_sys_in;

  // The whole run needs well under 2000 cycles, so 20000 only trips on a hang.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Ends at a falling edge, where the combinational routing has settled.
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask : ticks

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk_sys_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clk_sys_in);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge clk_sys_in);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rsp);
    logic ar_hs, r_hs;
    @(posedge clk_sys_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clk_sys_in);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk_sys_in);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic pc_set(input logic [10:0] v);
    logic [1:0] r;
    axi_wr(4'h0, {21'h0, v}, r);
    chk("pc write resp", 32'(r), 32'h0);
    ticks(2);
  endtask : pc_set

  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0] r;
    ticks(10);
    chk("default cfg", 32'({cfg3, speed_mode_out}), 32'({3'h0, SPEED_SINGLE}));
    chk("ctrl header oe", 32'(control_header_oe_out), 32'h1);
    axi_rd(4'h0, d, r);
    chk("pc cfg reset", d, 32'h100);
    axi_rd(4'h4, d, r);
    chk("status", 32'({d[18], d[10:0]}), 32'h900);
    axi_rd(4'hc, d, r);
    chk("unmapped rresp", 32'(r), 32'h2);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_clocks();
    @(posedge clk_sys_in);
    pc_cable_present_in <= 1'b1;
    ticks(6);
    for (int k = 0; k < 4; k++) begin
      pc_set(11'h100 | 11'(k) | 11'(k << 2));
      chk("sclk oe", 32'(s_oe), {28'h0, ~(4'h1 << k)});
      chk("lrck oe", 32'(l_oe), {28'h0, ~(4'h1 << k)});
      chk("codec mclk oe", 32'(codec_mclk_oe_out), 32'(k != 1));
      chk("header mclk oe", 32'(pcm_header_mclk_oe_out), 32'(k < 2));
      repeat (16) begin
        chk("tx mclk", 32'(tx_mclk_out), 32'(k == 0 ? m_i[1] : (k == 1 ? m_i[0] : m_i[2])));
        chk("codec mclk", 32'(codec_mclk_out), 32'(k == 0 ? m_i[1] : (k == 1 ? m_i[0] : m_i[2])));
        for (int i = 0; i < 4; i++) begin
          if (i != k) begin
            chk("sclk route", 32'(s_o[i]), 32'(s_i[k]));
            chk("lrck route", 32'(l_o[i]), 32'(l_i[k]));
          end
        end
        @(negedge clk_sys_in);
      end
    end
    $display("test clocks done");
  endtask : t_clocks

  task automatic t_fields();
    for (int k = 0; k < 4; k++) begin
      pc_set(((k & 1) ? 11'h4f0 : 11'h0) | 11'(k << 8));
      chk("format ratio coax", 32'(cfg3), (k & 1) ? 32'h7 : 32'h0);
      chk("speed", 32'(speed_mode_out), 32'(k));
      repeat (16) begin
        chk("codec in", 32'(codec_serial_data_in_out), 32'((k & 1) ? dat[2] : dat[1]));
        chk("tx in", 32'(tx_serial_data_in_out), 32'((k & 1) ? dat[3] : dat[0]));
        chk("copies", 32'({pcm_header_serial_data_out, rx_data_header_out}), 32'({dat[0], dat[1]}));
        @(negedge clk_sys_in);
      end
    end
    $display("test fields done");
  endtask : t_fields

  task automatic t_ctrl();
    chk("ctrl out", 32'({control_header_oe_out, control_header_out, codec_ctrl_out}), 32'h6d);
    @(posedge clk_sys_in);
    control_direction_jumper_in <= 1'b1;
    ticks(6);
    chk("ctrl in", 32'({control_header_oe_out, codec_ctrl_out}), 32'h2);
    @(posedge clk_sys_in);
    control_direction_jumper_in <= 1'b0;
    $display("test control done");
  endtask : t_ctrl

  task automatic t_switch();
    logic [31:0] d;
    logic [1:0] r;
    pc_set(11'h7f0);
    @(posedge clk_sys_in);
    switch_bank_in <= 10'h2f2;
    pc_cable_present_in <= 1'b0;
    ticks(6);
    chk("revert", 32'({cfg3, speed_mode_out}), 32'h1);
    axi_wr(4'h0, 32'h4f0, r);
    ticks(2);
    chk("pc ignored", 32'({cfg3, speed_mode_out}), 32'h1);
    axi_wr(4'h4, 32'h0, r);
    chk("ro write resp", 32'(r), 32'h0);
    axi_wr(4'hc, 32'h0, r);
    chk("unmapped bresp", 32'(r), 32'h2);
    // The operator presses board reset after moving switches.
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    ticks(10);
    chk("switch cfg", 32'({cfg3, speed_mode_out}), 32'h1e);
    chk("tx master", 32'(s_oe), 32'hb);
    axi_rd(4'h8, d, r);
    chk("switch reg", d, 32'h2f2);
    $display("test switches done");
  endtask : t_switch

  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_defaults();
    t_clocks();
    t_fields();
    t_ctrl();
    t_switch();
    wrap_up();
  end
endmodule : tb
